// *** common/vport_pkg.sv ***
// Summary of operation
// [RL1] Port bit 6 picks the horizontal reference: active-line pulse or sync.
// [RL2] Sync begins and ends in eight-cycle units, plus two-cycle fine steps.
// [RL3] Bits 5:4 pick vertical sync, field id, or either of them inverted.
// [RL4] Bit 3 picks the inverted lock status or the fast lock indicator.
// [RL5] Format 000 is 656 with codes, 010 drops codes, 011 and 110 reserved.
// [RL6] Format 001 blanks video outside the programmed vertical gate window.
// [RL7] Formats 100 and 101 bypass bits 8..1 or 7..0, muxed by chroma phase.
// [RL8] Format 111 sends one sample's high bits at phase 1, low at phase 0.
// [RL9] Software leaves compatibility bit off unless a re-encoder needs it.
// [RL10] Analog bit 6 updates gain once per line when 0, per field when 1.
// [RL11] A 3-bit select routes the test output; reserved codes give ground.
// [RL12] Analog bit 2 holds the chroma standard autodetect control flag.
// [RL13] Analog bits 1:0 set the converter sample-clock phase delay.
// [RL14] Output enable bits drive their pins when 1 and float them when 0.
// [RL15] The chroma phase reference toggles on every enabled pixel cycle.
// [RL16] Active-line reference marks 720 pixels per line, also in blanking.
package vport_pkg;
  localparam logic [7:0] PORT_CTRL_OFS   = 8'h13;
  localparam logic [7:0] ANALOG_CTRL_OFS = 8'h14;
  localparam logic [7:0] PORT_CTRL_RST   = 8'h00;
  localparam logic [7:0] ANALOG_CTRL_RST = 8'h00;
  localparam logic [7:0] RD_UNMAPPED     = 8'h00;
  // Port register fields.
  localparam int RTC_EN_BIT  = 7;
  localparam int ACTIVE_LINE_REF_SEL_BIT = 6;
  localparam int VREF_SEL_HI = 5;
  localparam int VREF_SEL_LO = 4;
  localparam int HLOCK_SEL_BIT = 3;
  localparam int FMT_HI      = 2;
  localparam int FMT_LO      = 0;
  // Analog register fields.
  localparam int COMPAT_BIT  = 7;
  localparam int GAIN_IV_BIT = 6;
  localparam int ATEST_HI    = 5;
  localparam int ATEST_LO    = 4;
  localparam int XTAL_EN_BIT = 3;
  localparam int AUTODET_BIT = 2;
  localparam int PHASE_HI    = 1;
  localparam int PHASE_LO    = 0;
  // Port formats.
  localparam logic [2:0] FMT_656      = 3'h0;
  localparam logic [2:0] FMT_656_GATE = 3'h1;
  localparam logic [2:0] FMT_422_RAW  = 3'h2;
  localparam logic [2:0] FMT_RSV3     = 3'h3;
  localparam logic [2:0] FMT_BYP_HI   = 3'h4;
  localparam logic [2:0] FMT_BYP_LO   = 3'h5;
  localparam logic [2:0] FMT_RSV6     = 3'h6;
  localparam logic [2:0] FMT_BYP_ONE  = 3'h7;
  // Vertical reference choices.
  localparam logic [1:0] VREF_VSYNC   = 2'h0;
  localparam logic [1:0] VREF_FID     = 2'h1;
  localparam logic [1:0] VREF_VSYNC_N = 2'h2;
  localparam logic [1:0] VREF_FID_N   = 2'h3;
  // Analog test codes.
  localparam logic [2:0] ATEST_GND    = 3'h0;
  localparam logic [2:0] ATEST_IN4    = 3'h4;
  localparam logic [2:0] ATEST_FILTER = 3'h7;
  // Line timing.
  localparam int LINE_PIXELS   = 858;
  localparam int ACTIVE_PIXELS = 720;
  localparam int ACTIVE_START  = 138;
  localparam logic [9:0] PIX_LAST   = 10'(LINE_PIXELS - 1);
  localparam logic [9:0] ACTIVE_LINE_REF_BEGIN = 10'(ACTIVE_START);
  localparam logic [9:0] ACTIVE_LINE_REF_END   = 10'(ACTIVE_START + ACTIVE_PIXELS);
  localparam int HS_UNIT_SHIFT = 3;
  localparam int HS_FINE_SHIFT = 1;
  // Blanking levels.
  localparam logic [7:0] BLANK_LUMA   = 8'h10;
  localparam logic [7:0] BLANK_CHROMA = 8'h80;
endpackage

// *** hdl/hsync_gen.sv ***
`timescale 1ns/10ps
module hsync_gen
  import vport_pkg::*;
(
  input  wire logic       MCLK,
  input  wire logic       RSTN,
  input  wire logic       CLK_EN,
  input  wire logic [9:0] PIX_CNT,
  input  wire logic [7:0] HS_BEGIN,
  input  wire logic [7:0] HS_STOP,
  input  wire logic [1:0] HS_FINE,
  output logic            HS_OUT
);
  logic [10:0] pix_ext;
  logic [10:0] win_begin;
  logic [10:0] win_stop;
  logic        hs_reg;
  logic        hs_next;

  // Window edges in pixel cycles; the fine delay moves both edges alike.
  always_comb begin
    pix_ext   = {1'b0, PIX_CNT};
    win_begin = (11'(HS_BEGIN) << HS_UNIT_SHIFT)
              + (11'(HS_FINE) << HS_FINE_SHIFT); // RL2
    win_stop  = (11'(HS_STOP) << HS_UNIT_SHIFT)
              + (11'(HS_FINE) << HS_FINE_SHIFT); // RL2
    hs_next   = (pix_ext >= win_begin) && (pix_ext < win_stop); // RL2
  end

  // A stop at or before the begin gives no pulse rather than a wrapped one.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      hs_reg <= 1'b0;
    end else if (CLK_EN) begin
      hs_reg <= hs_next;
    end
  end

  assign HS_OUT = hs_reg;

  AST_HS_WINDOW: assert property (@(posedge MCLK) disable iff (!RSTN) // RL2
    CLK_EN |=> HS_OUT == $past(hs_next))
    else $error("hsync does not follow its programmed window");
endmodule

// *** hdl/video_port_output_control.sv ***
`timescale 1ns/10ps
module video_port_output_control
  import vport_pkg::*;
(
  input  wire logic       MCLK,
  input  wire logic       RSTN,
  input  wire logic       CLK_EN,
  input  wire logic [7:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  output logic [7:0]      REG_RDATA,
  input  wire logic [7:0] HSYNC_BEGIN,
  input  wire logic [7:0] HSYNC_STOP,
  input  wire logic [1:0] HSYNC_FINE_DELAY,
  input  wire logic [8:0] GATE_START_LINE,
  input  wire logic [8:0] GATE_STOP_LINE,
  input  wire logic       GATE_POSITION_OPTION,
  input  wire logic       ANALOG_TEST_SELECT_MSB,
  input  wire logic       VERTICAL_SYNC_PULSE,
  input  wire logic       FIELD_ID,
  input  wire logic       HLOCK_STATUS,
  input  wire logic       FAST_HLOCK,
  input  wire logic [7:0] VIDEO_DATA,
  input  wire logic       VIDEO_IS_TRC,
  input  wire logic [8:0] ADC1_DATA,
  input  wire logic [8:0] ADC2_DATA,
  input  wire logic       TWO_ADC_ACTIVE,
  input  wire logic       REALTIME_CTRL_IN,
  input  wire logic       CRYSTAL_IN,
  output logic            EXP_HOR_REF_PIN,
  output logic            EXP_VERT_REF_PIN,
  output logic            HLOCK_INDICATOR,
  output logic [7:0]      EXP_PORT_DATA,
  output logic            CHROMA_PHASE_REF,
  output logic            REALTIME_CTRL_OUT,
  output logic            REALTIME_CTRL_OUT_OE,
  output logic            CRYSTAL_OUT,
  output logic            CRYSTAL_OUT_OE,
  output logic            GAIN_UPDATE,
  output logic [2:0]      ANALOG_TEST_SELECT,
  output logic            REENCODER_COMPAT,
  output logic            CHROMA_STD_AUTODETECT_CTL,
  output logic [1:0]      CONVERTER_CLOCK_PHASE
);
  // Reserved analog test codes collapse to ground so the pin never floats.
  function automatic logic [2:0] atest_route(input logic [2:0] code);
    if (code <= ATEST_IN4 || code == ATEST_FILTER) begin
      atest_route = code;
    end else begin
      atest_route = ATEST_GND;
    end
  endfunction

  // Reserved formats put a constant on the port.
  function automatic logic fmt_reserved(input logic [2:0] fmt);
    fmt_reserved = (fmt == FMT_RSV3) || (fmt == FMT_RSV6);
  endfunction

  logic [7:0] port_ctrl_reg;
  logic [7:0] port_ctrl_next;
  logic [7:0] analog_ctrl_reg;
  logic [7:0] analog_ctrl_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [9:0] pix_reg;
  logic [9:0] pix_next;
  logic [8:0] line_reg;
  logic [8:0] line_next;
  logic       vs_d_reg;
  logic       vs_d_next;
  logic       chroma_phase_ref_reg;
  logic       chroma_phase_ref_next;
  logic       active_line_ref_reg;
  logic       active_line_ref_next;
  logic       gain_reg;
  logic       gain_next;
  logic       xtal_reg;
  logic       xtal_next;
  logic       rtc_reg;
  logic       rtc_next;
  logic [7:0] data_reg;
  logic [7:0] data_next;
  logic       hs_pulse;
  logic       line_start;
  logic       field_start;
  logic       gate_active;
  logic [8:0] gate_line;
  logic [2:0] fmt;
  logic [8:0] byp_sample;

  assign fmt = port_ctrl_reg[FMT_HI:FMT_LO];

  // Register writes and reads; reads answer one enabled cycle later.
  always_comb begin
    port_ctrl_next   = port_ctrl_reg;
    analog_ctrl_next = analog_ctrl_reg;
    rdata_next       = rdata_reg;
    if (REG_WR && REG_ADDR == PORT_CTRL_OFS) begin
      port_ctrl_next = REG_WDATA;
    end
    if (REG_WR && REG_ADDR == ANALOG_CTRL_OFS) begin
      analog_ctrl_next = REG_WDATA;
    end
    if (REG_RD) begin
      case (REG_ADDR)
        PORT_CTRL_OFS:   rdata_next = port_ctrl_reg;
        ANALOG_CTRL_OFS: rdata_next = analog_ctrl_reg;
        default:         rdata_next = RD_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      port_ctrl_reg   <= PORT_CTRL_RST;
      analog_ctrl_reg <= ANALOG_CTRL_RST;
      rdata_reg       <= RD_UNMAPPED;
    end else if (CLK_EN) begin
      port_ctrl_reg   <= port_ctrl_next;
      analog_ctrl_reg <= analog_ctrl_next;
      rdata_reg       <= rdata_next;
    end
  end

  assign REG_RDATA = rdata_reg;

  // Line and field timing. The line counter restarts on the rising vertical
  // sync, so the gate compares against lines counted from the field start.
  always_comb begin
    line_start  = (pix_reg == PIX_LAST);
    field_start = VERTICAL_SYNC_PULSE && !vs_d_reg;
    pix_next    = line_start ? '0 : pix_reg + 10'h001;
    line_next   = line_reg;
    if (field_start) begin
      line_next = '0;
    end else if (line_start) begin
      line_next = line_reg + 9'h001;
    end
    vs_d_next = VERTICAL_SYNC_PULSE;
    chroma_phase_ref_next = !chroma_phase_ref_reg; // RL15
    active_line_ref_next = (pix_next >= ACTIVE_LINE_REF_BEGIN) && (pix_next < ACTIVE_LINE_REF_END); // RL16
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      pix_reg  <= '0;
      line_reg <= '0;
      vs_d_reg <= 1'b0;
      chroma_phase_ref_reg <= 1'b0;
      active_line_ref_reg <= 1'b0;
    end else if (CLK_EN) begin
      pix_reg  <= pix_next;
      line_reg <= line_next;
      vs_d_reg <= vs_d_next;
      chroma_phase_ref_reg <= chroma_phase_ref_next;
      active_line_ref_reg <= active_line_ref_next;
    end
  end

  assign CHROMA_PHASE_REF = chroma_phase_ref_reg;

  hsync_gen u_hsync (
    .MCLK     (MCLK),
    .RSTN     (RSTN),
    .CLK_EN   (CLK_EN),
    .PIX_CNT  (pix_reg),
    .HS_BEGIN (HSYNC_BEGIN),
    .HS_STOP  (HSYNC_STOP),
    .HS_FINE  (HSYNC_FINE_DELAY),
    .HS_OUT   (hs_pulse)
  );

  // The alternate gate position moves the window one line earlier in
  // the second field, done here by looking one line ahead.
  always_comb begin
    gate_line = (GATE_POSITION_OPTION && FIELD_ID) ?
                line_reg + 9'h001 : line_reg; // RL6
    gate_active = (gate_line >= GATE_START_LINE) &&
                  (gate_line < GATE_STOP_LINE); // RL6
  end

  // Bypass sample choice: the second converter at phase 1 when two run.
  assign byp_sample = (TWO_ADC_ACTIVE && chroma_phase_ref_reg) ? ADC2_DATA : ADC1_DATA;

  // Port data format multiplexer, registered for a clean pin.
  always_comb begin
    data_next = VIDEO_DATA;
    case (fmt)
      FMT_656: data_next = VIDEO_DATA; // RL5
      FMT_656_GATE: begin
        if (!gate_active && !VIDEO_IS_TRC) begin // RL6
          data_next = chroma_phase_ref_reg ? BLANK_CHROMA : BLANK_LUMA;
        end
      end
      FMT_422_RAW: begin
        if (VIDEO_IS_TRC) begin // RL5
          data_next = chroma_phase_ref_reg ? BLANK_CHROMA : BLANK_LUMA;
        end
      end
      FMT_BYP_HI:  data_next = byp_sample[8:1]; // RL7
      FMT_BYP_LO:  data_next = byp_sample[7:0]; // RL7
      FMT_BYP_ONE: data_next = chroma_phase_ref_reg ? ADC1_DATA[8:1]
                                        : ADC1_DATA[7:0]; // RL8
      default:     data_next = '0; // RL5
    endcase
  end

  // Gain update strobe and the registered pin drivers.
  always_comb begin
    gain_next = analog_ctrl_reg[GAIN_IV_BIT] ? field_start
                                             : line_start; // RL10
    xtal_next = CRYSTAL_IN;
    rtc_next  = REALTIME_CTRL_IN;
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      data_reg <= '0;
      gain_reg <= 1'b0;
      xtal_reg <= 1'b0;
      rtc_reg  <= 1'b0;
    end else if (CLK_EN) begin
      data_reg <= data_next;
      gain_reg <= gain_next;
      xtal_reg <= xtal_next;
      rtc_reg  <= rtc_next;
    end
  end

  // Gain strobe is gated so a frozen clock does not stretch the pulse.
  assign GAIN_UPDATE   = gain_reg && CLK_EN;
  assign EXP_PORT_DATA = data_reg;

  // Reference pins and lock indicator.
  always_comb begin
    EXP_HOR_REF_PIN = port_ctrl_reg[ACTIVE_LINE_REF_SEL_BIT] ? hs_pulse
                                                  : active_line_ref_reg; // RL1
    case (port_ctrl_reg[VREF_SEL_HI:VREF_SEL_LO])
      VREF_VSYNC:   EXP_VERT_REF_PIN = VERTICAL_SYNC_PULSE; // RL3
      VREF_FID:     EXP_VERT_REF_PIN = FIELD_ID; // RL3
      VREF_VSYNC_N: EXP_VERT_REF_PIN = !VERTICAL_SYNC_PULSE; // RL3
      VREF_FID_N:   EXP_VERT_REF_PIN = !FIELD_ID; // RL3
      default:      EXP_VERT_REF_PIN = VERTICAL_SYNC_PULSE;
    endcase
    HLOCK_INDICATOR = port_ctrl_reg[HLOCK_SEL_BIT] ? FAST_HLOCK
                                                   : !HLOCK_STATUS; // RL4
  end

  // Tri-state pins: the enable is the register bit itself.
  assign REALTIME_CTRL_OUT    = rtc_reg;
  assign REALTIME_CTRL_OUT_OE = port_ctrl_reg[RTC_EN_BIT]; // RL14
  assign CRYSTAL_OUT          = xtal_reg;
  assign CRYSTAL_OUT_OE       = analog_ctrl_reg[XTAL_EN_BIT]; // RL14

  // Analog and misc control outputs.
  assign ANALOG_TEST_SELECT = atest_route({ANALOG_TEST_SELECT_MSB,
    analog_ctrl_reg[ATEST_HI:ATEST_LO]}); // RL11
  assign REENCODER_COMPAT          = analog_ctrl_reg[COMPAT_BIT];
  assign CHROMA_STD_AUTODETECT_CTL = analog_ctrl_reg[AUTODET_BIT]; // RL12
  assign CONVERTER_CLOCK_PHASE     = analog_ctrl_reg[PHASE_HI:PHASE_LO]; // RL13

  // Helper: enabled cycles the running active-line pulse has lasted before this one.
  logic [9:0] active_line_ref_len;
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      active_line_ref_len <= '0;
    end else if (CLK_EN) begin
      active_line_ref_len <= active_line_ref_reg ? active_line_ref_len + 10'h001 : '0;
    end
  end

  AST_ACTIVE_LINE_REF_WIDTH: assert property (@(posedge MCLK) disable iff (!RSTN) // RL16
    (CLK_EN && active_line_ref_reg && !active_line_ref_next) |-> active_line_ref_len == 10'(ACTIVE_PIXELS - 1))
    else $error("active line pulse is not 720 pixels");
  AST_CHROMA_PHASE_REF_TOGGLE: assert property (@(posedge MCLK) disable iff (!RSTN) // RL15
    CLK_EN |=> CHROMA_PHASE_REF != $past(CHROMA_PHASE_REF))
    else $error("chroma phase did not toggle");
  // The active-line side is judged from the pixel count, not from its flop.
  AST_ACTIVE_LINE_REF_SELECT: assert property (@(posedge MCLK) disable iff (!RSTN) // RL1
    EXP_HOR_REF_PIN == (port_ctrl_reg[ACTIVE_LINE_REF_SEL_BIT] ? hs_pulse
      : ((pix_reg >= ACTIVE_LINE_REF_BEGIN) && (pix_reg < ACTIVE_LINE_REF_END))))
    else $error("horizontal reference pin has wrong source");
  AST_VREF_INV: assert property (@(posedge MCLK) disable iff (!RSTN) // RL3
    (port_ctrl_reg[VREF_SEL_HI:VREF_SEL_LO] == VREF_FID_N)
      |-> EXP_VERT_REF_PIN != FIELD_ID)
    else $error("vertical reference not inverted field id");
  AST_HLOCK: assert property (@(posedge MCLK) disable iff (!RSTN) // RL4
    !port_ctrl_reg[HLOCK_SEL_BIT] |-> HLOCK_INDICATOR == !HLOCK_STATUS)
    else $error("lock indicator is not the inverted status");
  AST_BYPASS_HI: assert property (@(posedge MCLK) disable iff (!RSTN) // RL7
    (CLK_EN && fmt == FMT_BYP_HI && TWO_ADC_ACTIVE && chroma_phase_ref_reg
      && $stable(port_ctrl_reg))
      |=> EXP_PORT_DATA == $past(ADC2_DATA[8:1]))
    else $error("bypass high bits wrong for second converter");
  AST_BYPASS_ONE: assert property (@(posedge MCLK) disable iff (!RSTN) // RL8
    (CLK_EN && fmt == FMT_BYP_ONE && !chroma_phase_ref_reg)
      |=> EXP_PORT_DATA == $past(ADC1_DATA[7:0]))
    else $error("single converter low bits wrong");
  AST_RESERVED: assert property (@(posedge MCLK) disable iff (!RSTN) // RL5
    (CLK_EN && fmt_reserved(fmt)) |=> EXP_PORT_DATA == 8'h00)
    else $error("reserved format drives data");
  // A strobe that waited out a freeze has no launching cycle just behind it.
  AST_GAIN_LINE: assert property (@(posedge MCLK) disable iff (!RSTN) // RL10
    (GAIN_UPDATE && $past(CLK_EN) && !$past(analog_ctrl_reg[GAIN_IV_BIT]))
      |-> $past(pix_reg) == PIX_LAST)
    else $error("line gain update off the line start");
  AST_OE: assert property (@(posedge MCLK) disable iff (!RSTN) // RL14
    CLK_EN && REG_WR && REG_ADDR == PORT_CTRL_OFS
      |=> REALTIME_CTRL_OUT_OE == $past(REG_WDATA[RTC_EN_BIT]))
    else $error("realtime output enable not taken from write");
  AST_ATEST_RSV: assert property (@(posedge MCLK) disable iff (!RSTN) // RL11
    ({ANALOG_TEST_SELECT_MSB, analog_ctrl_reg[ATEST_HI:ATEST_LO]} == 3'h5)
      |-> ANALOG_TEST_SELECT == ATEST_GND)
    else $error("reserved analog test code not grounded");

  COV_GATE_FMT: cover property (@(posedge MCLK) disable iff (!RSTN)
    fmt == FMT_656_GATE && !gate_active);
  COV_BYP_TWO: cover property (@(posedge MCLK) disable iff (!RSTN)
    fmt == FMT_BYP_LO && TWO_ADC_ACTIVE);
  COV_HS_SEL: cover property (@(posedge MCLK) disable iff (!RSTN)
    port_ctrl_reg[ACTIVE_LINE_REF_SEL_BIT] && hs_pulse);
endmodule

// *** tb/vport_codec_sink.sv ***
`timescale 1ns/10ps
// Receiving codec on the expansion port. It only listens, and it times the
// horizontal reference pin: the high length and the rise-to-rise period.
module vport_codec_sink (
  input  wire logic mclk,
  input  wire logic rstn,
  input  wire logic ref_pin,
  output int        high_len,
  output int        period,
  output int        rise_cnt
);
  logic ref_d;
  int   run_len;
  int   since_rise;

  // Lengths are only taken at edges of the pin, so a partial pulse left by
  // a select change is replaced by the next whole one.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ref_d      <= 1'b0;
      run_len    <= 0;
      since_rise <= 0;
      high_len   <= 0;
      period     <= 0;
      rise_cnt   <= 0;
    end else begin
      ref_d      <= ref_pin;
      run_len    <= ref_pin ? run_len + 1 : 0;
      since_rise <= since_rise + 1;
      if (ref_pin && !ref_d) begin
        period     <= since_rise;
        since_rise <= 1;
        rise_cnt   <= rise_cnt + 1;
      end
      if (!ref_pin && ref_d) begin
        high_len <= run_len;
      end
    end
  end
endmodule

// *** tb/tb_video_port_output_control.sv ***
`timescale 1ns/10ps
module tb_video_port_output_control;
  import vport_pkg::*;
  logic       MCLK = 1'b0, RSTN = 1'b0, CLK_EN = 1'b1, REG_WR = 1'b0;
  logic       REG_RD = 1'b0, GATE_POSITION_OPTION = 1'b0, FIELD_ID = 1'b0;
  logic       ANALOG_TEST_SELECT_MSB = 1'b0, VERTICAL_SYNC_PULSE = 1'b0;
  logic       HLOCK_STATUS = 1'b0, FAST_HLOCK = 1'b0, VIDEO_IS_TRC = 1'b0;
  logic       TWO_ADC_ACTIVE = 1'b0, REALTIME_CTRL_IN = 1'b0;
  logic       CRYSTAL_IN = 1'b0, gate_on = 1'b0;
  logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00, VIDEO_DATA = 8'h00;
  logic [7:0] HSYNC_BEGIN = 8'h00, HSYNC_STOP = 8'h00;
  logic [1:0] HSYNC_FINE_DELAY = 2'h0;
  logic [8:0] GATE_START_LINE = 9'h000, GATE_STOP_LINE = 9'h000;
  logic [8:0] ADC1_DATA = 9'h000, ADC2_DATA = 9'h000;
  logic [7:0] REG_RDATA, EXP_PORT_DATA;
  logic       EXP_HOR_REF_PIN, EXP_VERT_REF_PIN, HLOCK_INDICATOR;
  logic       CHROMA_PHASE_REF, REALTIME_CTRL_OUT, REALTIME_CTRL_OUT_OE;
  logic       CRYSTAL_OUT, CRYSTAL_OUT_OE, GAIN_UPDATE, REENCODER_COMPAT;
  logic       CHROMA_STD_AUTODETECT_CTL;
  logic [2:0] ANALOG_TEST_SELECT;
  logic [1:0] CONVERTER_CLOCK_PHASE;
  int         error_cnt = 0, tests_run = 0, high_len, period, rise_cnt;

  video_port_output_control dut_u (.*);
  vport_codec_sink sink_u (.mclk(MCLK), .rstn(RSTN),
    .ref_pin(EXP_HOR_REF_PIN), .high_len(high_len), .period(period),
    .rise_cnt(rise_cnt));

  // Pixel clock at 100 MHz.
  always #5 MCLK = ~MCLK;

  // Verdict, reached from the end of the run and from any expired wait.
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] exp,
                       input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One write strobe, held across exactly one edge.
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge MCLK);
    REG_ADDR  <= a;
    REG_WDATA <= d;
    REG_WR    <= 1'b1;
    @(posedge MCLK);
    REG_WR    <= 1'b0;
  endtask

  // Read data is registered, so it is looked at just after the taking edge.
  task automatic read_check(input logic [7:0] a, input logic [7:0] e,
                            input string name);
    @(posedge MCLK);
    REG_ADDR <= a;
    REG_RD   <= 1'b1;
    @(posedge MCLK);
    REG_RD   <= 1'b0;
    #1;
    check(name, 16'(e), 16'(REG_RDATA));
  endtask

  // Reference model of the port byte for the inputs now applied.
  function automatic logic [7:0] exp_byte(input logic [2:0] f,
                                          input logic c);
    logic [8:0] s;
    logic [7:0] b;
    s = (c && TWO_ADC_ACTIVE) ? ADC2_DATA : ADC1_DATA;
    b = c ? BLANK_CHROMA : BLANK_LUMA;
    case (f)
      FMT_656:      return VIDEO_DATA;
      FMT_656_GATE: return (VIDEO_IS_TRC || gate_on) ? VIDEO_DATA : b;
      FMT_422_RAW:  return VIDEO_IS_TRC ? b : VIDEO_DATA;
      FMT_BYP_HI:   return s[8:1];
      FMT_BYP_LO:   return s[7:0];
      FMT_BYP_ONE:  return c ? ADC1_DATA[8:1] : ADC1_DATA[7:0];
      default:      return 8'h00;
    endcase
  endfunction

  // Random video every cycle; what one edge takes is compared a cycle later.
  task automatic stream(input logic [2:0] f, input int n);
    logic [7:0] e;
    logic [2:0] p;
    for (int i = 0; i <= n; i++) begin
      @(posedge MCLK);
      VIDEO_DATA       <= 8'($urandom);
      VIDEO_IS_TRC     <= 1'($urandom);
      ADC1_DATA        <= 9'($urandom);
      ADC2_DATA        <= 9'($urandom);
      TWO_ADC_ACTIVE   <= 1'($urandom) && f != FMT_BYP_ONE;
      REALTIME_CTRL_IN <= 1'($urandom);
      CRYSTAL_IN       <= 1'($urandom);
      #1;
      if (i > 0) begin
        check("port_data", 16'(e), 16'(EXP_PORT_DATA));
        check("phase_ref", 16'(!p[0]), 16'(CHROMA_PHASE_REF));
        check("pins", 16'(p[2:1]), 16'({REALTIME_CTRL_OUT, CRYSTAL_OUT}));
      end
      e = exp_byte(f, CHROMA_PHASE_REF);
      p = {REALTIME_CTRL_IN, CRYSTAL_IN, CHROMA_PHASE_REF};
    end
  endtask

  // A line is 858 cycles, so 1000 per rise bounds the wait with margin.
  task automatic wait_rises(input int n);
    int start;
    int k;
    start = rise_cnt;
    k = 0;
    while (rise_cnt < start + n && k < n * 1000) begin
      @(posedge MCLK);
      k++;
    end
    if (rise_cnt < start + n) begin
      check("ref_rises", 16'(n), 16'(rise_cnt - start));
      print_verdict();
    end
  endtask

  // Counts gain update pulses; an optional vertical sync rise at cycle vs.
  task automatic count_gain(input int n, input int vs, output int k);
    k = 0;
    for (int i = 0; i < n; i++) begin
      @(posedge MCLK);
      VERTICAL_SYNC_PULSE <= (i >= vs && vs >= 0);
      #1;
      if (GAIN_UPDATE === 1'b1) k++;
    end
    @(posedge MCLK);
    VERTICAL_SYNC_PULSE <= 1'b0;
  endtask

  initial begin
    logic [7:0] v;
    logic [7:0] w;
    logic       e;
    int         k;
    void'($urandom(32'h61549B55));
    repeat (4) @(posedge MCLK);
    RSTN <= 1'b1;
    read_check(PORT_CTRL_OFS, PORT_CTRL_RST, "port_rst");
    read_check(ANALOG_CTRL_OFS, ANALOG_CTRL_RST, "analog_rst");
    check("oe_rst", 16'h0000, 16'({REALTIME_CTRL_OUT_OE, CRYSTAL_OUT_OE}));
    // Both registers with every analog test code and random other fields.
    for (int i = 0; i < 8; i++) begin
      v = 8'($urandom);
      v[7] = i[0];
      w = 8'($urandom);
      w[5:4] = i[1:0];
      w[7] = w[7] & v[7];
      @(posedge MCLK);
      ANALOG_TEST_SELECT_MSB <= i[2];
      reg_write(PORT_CTRL_OFS, v);
      reg_write(ANALOG_CTRL_OFS, w);
      read_check(PORT_CTRL_OFS, v, "port_rd");
      read_check(ANALOG_CTRL_OFS, w, "analog_rd");
      check("rtc_oe", 16'(v[7]), 16'(REALTIME_CTRL_OUT_OE));
      check("xtal_oe", 16'(w[3]), 16'(CRYSTAL_OUT_OE));
      check("compat", 16'(w[7]), 16'(REENCODER_COMPAT));
      check("autodet", 16'(w[2]), 16'(CHROMA_STD_AUTODETECT_CTL));
      check("phase", 16'(w[1:0]), 16'(CONVERTER_CLOCK_PHASE));
      check("atest", 16'((i == 5 || i == 6) ? 0 : i), 16'(ANALOG_TEST_SELECT));
    end
    // Unmapped places read zero and leave the real registers alone.
    reg_write(8'h20, 8'hFF);
    read_check(8'h20, RD_UNMAPPED, "unmapped");
    read_check(PORT_CTRL_OFS, v, "port_kept");
    // With the clock enable low a write must not land.
    @(posedge MCLK);
    CLK_EN <= 1'b0;
    reg_write(PORT_CTRL_OFS, ~v);
    @(posedge MCLK);
    CLK_EN <= 1'b1;
    read_check(PORT_CTRL_OFS, v, "frozen");
    // Every vertical reference code, with both lock indicator choices.
    for (int i = 0; i < 32; i++) begin
      if (i % 4 == 0) begin
        reg_write(PORT_CTRL_OFS, {2'h0, 2'(i >> 2), 1'(i >> 4), 3'h0});
      end
      @(posedge MCLK);
      VERTICAL_SYNC_PULSE <= 1'($urandom);
      FIELD_ID            <= 1'($urandom);
      HLOCK_STATUS        <= 1'($urandom);
      FAST_HLOCK          <= 1'($urandom);
      #1;
      e = (i[2] ? FIELD_ID : VERTICAL_SYNC_PULSE) ^ i[3];
      check("vert_ref", 16'(e), 16'(EXP_VERT_REF_PIN));
      e = i[4] ? FAST_HLOCK : !HLOCK_STATUS;
      check("hlock", 16'(e), 16'(HLOCK_INDICATOR));
    end
    // All formats, with the gate window covering all lines or none. The third
    // pass restarts the line count and opens line zero only through the
    // one-line-early option in the second field.
    for (int g = 0; g < 3; g++) begin
      @(posedge MCLK);
      VERTICAL_SYNC_PULSE  <= (g == 2);
      GATE_START_LINE      <= 9'(g == 2);
      GATE_STOP_LINE       <= (g == 1) ? 9'h000 : 9'h1FF;
      GATE_POSITION_OPTION <= (g == 2);
      FIELD_ID             <= (g == 2);
      gate_on = (g != 1);
      for (int f = 0; f < 8; f++) begin
        reg_write(PORT_CTRL_OFS, {5'h10, 3'(f)});
        stream(3'(f), 40);
      end
    end
    // Active-line reference, then the programmable sync on the same pin.
    reg_write(PORT_CTRL_OFS, 8'h00);
    wait_rises(3);
    check("active_line_ref_len", 16'(ACTIVE_PIXELS), 16'(high_len));
    check("line_len", 16'(LINE_PIXELS), 16'(period));
    k = 1 + $urandom_range(39);
    @(posedge MCLK);
    HSYNC_BEGIN      <= 8'(k);
    HSYNC_STOP       <= 8'(k + 1 + $urandom_range(19));
    HSYNC_FINE_DELAY <= 2'($urandom);
    reg_write(PORT_CTRL_OFS, 8'h40);
    wait_rises(3);
    check("hs_len", 16'(8 * (HSYNC_STOP - HSYNC_BEGIN)), 16'(high_len));
    check("hs_period", 16'(LINE_PIXELS), 16'(period));
    // Gain updates: two line starts in two lines, or one field start.
    reg_write(ANALOG_CTRL_OFS, 8'h00);
    count_gain(1716, -1, k);
    check("gain_line", 16'h0002, 16'(k));
    reg_write(ANALOG_CTRL_OFS, 8'h40);
    count_gain(1716, 800, k);
    check("gain_field", 16'h0001, 16'(k));
    print_verdict();
  end
endmodule
